// [ffc_defines.vh]
`ifndef FFC_DEFINES_VH
`define FFC_DEFINES_VH

// Register addresses in the model-specific register space.
`define FFC_ADDR_CTR0 12'h309
`define FFC_ADDR_CTR1 12'h30A
`define FFC_ADDR_CTR2 12'h30B
`define FFC_ADDR_CAPS 12'h345
`define FFC_ADDR_CTRL 12'h38D
`define FFC_ADDR_GLOB 12'h38F

// Control register field positions, counter n uses base 4*n.
`define FFC_CTRL_SUP 0
`define FFC_CTRL_USR 1
`define FFC_CTRL_ANY 2
`define FFC_CTRL_IRQ 3
`define FFC_CTRL_W   12

// Capability register field positions.
`define FFC_CAP_BRF_LSB  0
`define FFC_CAP_PTRAP    6
`define FFC_CAP_PSAVE    7
`define FFC_CAP_PFMT_LSB 8
`define FFC_CAP_FRZ      12
`define FFC_CAP_FULLW    13

// Reset values.
`define FFC_CTRL_RST 12'h000
`define FFC_GLOB_RST 3'h0
`define FFC_CTR_RST  48'h0000_0000_0000

`endif

// [ffc_counter.v]
`timescale 1ns/10ps
`default_nettype none
module ffc_counter #(
    parameter W = 48
) (
    input  wire         clk_i,
    input  wire         reset_i,
    input  wire         wr_i,
    input  wire [W-1:0] wdata_i,
    input  wire         inc_i,
    output reg  [W-1:0] count_o,
    output reg          wrap_o
);
    always @(posedge clk_i) begin
        if (reset_i) begin
            count_o <= {W{1'b0}};
            wrap_o  <= 1'b0;
        end else if (wr_i) begin
            count_o <= wdata_i;
            wrap_o  <= 1'b0;
        end else begin
            wrap_o <= inc_i && (&count_o);
            if (inc_i) begin
                count_o <= count_o + {{(W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule
`default_nettype wire

// [ffc_privilege_gate.v]
`timescale 1ns/10ps
`default_nettype none
module ffc_privilege_gate (
    input  wire       clk_i,
    input  wire       reset_i,
    input  wire       global_en_i,
    input  wire       sup_en_i,
    input  wire       usr_en_i,
    input  wire       any_en_i,
    input  wire [1:0] priv_i,
    input  wire       own_ev_i,
    input  wire       sib_ev_i,
    input  wire       freeze_i,
    output reg        inc_o
);
    always @(posedge clk_i) begin
        if (reset_i) begin
            inc_o <= 1'b0;
        end else begin
            inc_o <= global_en_i && !freeze_i
                && ((priv_i == 2'd0) ? sup_en_i : usr_en_i)
                && (own_ev_i || (any_en_i && sib_ev_i));
        end
    end
endmodule
`default_nettype wire

// [ffc_fixed_counters.v]
// Overview of operation
// - Counter 0 counts retired instructions, read/write.
// - Counter 1 counts unhalted core cycles, read/write.
// - Counter 2 counts unhalted reference cycles, read/write.
// - Count only when global AND privilege enable.
// - Bit 0 enables counter 0 at privilege zero.
// - Bit 1 enables counter 0 above privilege zero.
// - Capability bit 12 reports freeze in management mode.
// - Capability bit 13 reports full-width alias writes.
// - Counters and control exist per reported feature values.
// - Bits 4,5 and 8,9 enable counters 1, 2.
// - Bits 3,7,11 raise interrupt on overflow.
// - Bits 2,6,10 count all sharing threads.
// - Control bits 63 to 12 reserved, read zero.
`timescale 1ns/10ps
`default_nettype none
`include "ffc_defines.vh"
module ffc_fixed_counters #(
    parameter       W          = 48,
    parameter [4:0] NUM_FIXED  = 5'd3,
    parameter [7:0] PMU_VER    = 8'd3,
    parameter [5:0] BRF_FMT    = 6'h00,
    parameter       PREC_TRAP  = 1'b0,
    parameter       PREC_SAVE  = 1'b0,
    parameter [3:0] PREC_FMT   = 4'h0,
    parameter       FREEZE_MGMT = 1'b1,
    parameter       FULL_WIDTH = 1'b1
) (
    input  wire        clk_i,
    input  wire        reset_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    input  wire [11:0] reg_addr_i,
    input  wire [63:0] reg_wdata_i,
    output reg  [63:0] reg_rdata_o,
    output reg         reg_ack_o,
    output reg         reg_err_o,
    input  wire [1:0]  current_privilege_level_i,
    input  wire        system_management_mode_i,
    input  wire        instr_retired_i,
    input  wire        core_unhalted_i,
    input  wire        ref_unhalted_i,
    input  wire        sib_instr_retired_i,
    input  wire        sib_core_unhalted_i,
    input  wire        sib_ref_unhalted_i,
    output reg         counter_overflow_interrupt_o,
    output reg  [2:0]  overflow_status_o
);
    reg  [`FFC_CTRL_W-1:0] fixed_counter_control_q;
    reg  [2:0]             global_counter_enable_q;
    reg                    freeze_q;
    wire [W-1:0]           cnt [0:2];
    wire [2:0]             inc;
    wire [2:0]             wrap;
    wire [2:0]             own_ev = {ref_unhalted_i, core_unhalted_i, instr_retired_i};
    wire [2:0]             sib_ev = {sib_ref_unhalted_i, sib_core_unhalted_i,
                                     sib_instr_retired_i};
    wire [2:0]             ctr_hit;
    wire                   ctrl_ok = (PMU_VER > 8'd1);
    wire [63:0]            caps;

    function [W-1:0] trunc;
        input [63:0] v;
        begin
            trunc = v[W-1:0];
        end
    endfunction

    assign ctr_hit[0] = (reg_addr_i == `FFC_ADDR_CTR0) && (NUM_FIXED > 5'd0);
    assign ctr_hit[1] = (reg_addr_i == `FFC_ADDR_CTR1) && (NUM_FIXED > 5'd1);
    assign ctr_hit[2] = (reg_addr_i == `FFC_ADDR_CTR2) && (NUM_FIXED > 5'd2);

    assign caps = {50'd0, FULL_WIDTH[0], FREEZE_MGMT[0], PREC_FMT, PREC_SAVE[0],
                   PREC_TRAP[0], BRF_FMT};

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : gen_ctr
            ffc_privilege_gate u_gate (
                .clk_i       (clk_i),
                .reset_i     (reset_i),
                .global_en_i (global_counter_enable_q[g]),
                .sup_en_i    (fixed_counter_control_q[4*g+`FFC_CTRL_SUP]),
                .usr_en_i    (fixed_counter_control_q[4*g+`FFC_CTRL_USR]),
                .any_en_i    (fixed_counter_control_q[4*g+`FFC_CTRL_ANY]),
                .priv_i      (current_privilege_level_i),
                .own_ev_i    (own_ev[g]),
                .sib_ev_i    (sib_ev[g]),
                .freeze_i    (freeze_q),
                .inc_o       (inc[g])
            );
            ffc_counter #(.W(W)) u_ctr (
                .clk_i   (clk_i),
                .reset_i (reset_i),
                .wr_i    (reg_wr_i && ctr_hit[g]),
                .wdata_i (trunc(reg_wdata_i)),
                .inc_i   (inc[g] && (NUM_FIXED > g)),
                .count_o (cnt[g]),
                .wrap_o  (wrap[g])
            );
        end
    endgenerate

    always @(posedge clk_i) begin
        if (reset_i) begin
            fixed_counter_control_q      <= `FFC_CTRL_RST;
            global_counter_enable_q      <= `FFC_GLOB_RST;
            freeze_q                     <= 1'b0;
            overflow_status_o            <= 3'b000;
            counter_overflow_interrupt_o <= 1'b0;
            reg_rdata_o                  <= 64'h0000_0000_0000_0000;
            reg_ack_o                    <= 1'b0;
            reg_err_o                    <= 1'b0;
        end else begin
            freeze_q <= FREEZE_MGMT && system_management_mode_i;
            if (reg_wr_i && ctrl_ok && reg_addr_i == `FFC_ADDR_CTRL) begin
                fixed_counter_control_q <= reg_wdata_i[`FFC_CTRL_W-1:0];
            end
            if (reg_wr_i && reg_addr_i == `FFC_ADDR_GLOB) begin
                global_counter_enable_q <= reg_wdata_i[2:0];
            end
            overflow_status_o <= overflow_status_o | wrap;
            counter_overflow_interrupt_o <= |(wrap & {fixed_counter_control_q[11],
                fixed_counter_control_q[7], fixed_counter_control_q[3]});
            reg_ack_o   <= reg_wr_i || reg_rd_i;
            reg_err_o   <= 1'b0;
            reg_rdata_o <= 64'h0000_0000_0000_0000;
            if (reg_rd_i || reg_wr_i) begin
                if (ctr_hit[0]) begin
                    reg_rdata_o <= {{(64-W){1'b0}}, cnt[0]};
                end else if (ctr_hit[1]) begin
                    reg_rdata_o <= {{(64-W){1'b0}}, cnt[1]};
                end else if (ctr_hit[2]) begin
                    reg_rdata_o <= {{(64-W){1'b0}}, cnt[2]};
                end else if (reg_addr_i == `FFC_ADDR_CAPS) begin
                    reg_rdata_o <= caps;
                end else if (reg_addr_i == `FFC_ADDR_CTRL && ctrl_ok) begin
                    reg_rdata_o <= {52'd0, fixed_counter_control_q};
                end else if (reg_addr_i == `FFC_ADDR_GLOB) begin
                    reg_rdata_o <= {61'd0, global_counter_enable_q};
                end else begin
                    reg_err_o <= 1'b1;
                end
                if (reg_wr_i) begin
                    reg_rdata_o <= 64'h0000_0000_0000_0000;
                end
            end
        end
    end
endmodule
`default_nettype wire

// [ffc_checker.sv]
`timescale 1ns/10ps
`default_nettype none
`include "ffc_defines.vh"
module ffc_checker #(
    parameter W = 48
) (
    input wire logic        clk_i,
    input wire logic        reset_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [11:0] reg_addr_i,
    input wire logic [63:0] reg_rdata_o,
    input wire logic        reg_ack_o,
    input wire logic        reg_err_o,
    input wire logic        counter_overflow_interrupt_o,
    input wire logic [2:0]  overflow_status_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    wire logic rq     = reg_rd_i | reg_wr_i;
    wire logic ctr    = reg_addr_i >= `FFC_ADDR_CTR0 && reg_addr_i <= `FFC_ADDR_CTR2;
    wire logic mapped = ctr || reg_addr_i == `FFC_ADDR_CAPS || reg_addr_i == `FFC_ADDR_CTRL
        || reg_addr_i == `FFC_ADDR_GLOB;
    a_ack_after_req: assert property (rq |=> reg_ack_o) else $error("ack missing");
    a_no_stray_ack: assert property (!rq |=> !reg_ack_o && !reg_err_o) else $error("stray ack");
    a_err_unmapped: assert property (rq && !mapped |=> reg_err_o && reg_rdata_o == 64'h0)
        else $error("unmapped not refused");
    a_caps_fixed: assert property (reg_rd_i && reg_addr_i == `FFC_ADDR_CAPS |=>
        reg_rdata_o[63:12] == 52'h3 && !reg_err_o) else $error("caps bits wrong");
    a_ctrl_reserved: assert property (reg_rd_i && reg_addr_i == `FFC_ADDR_CTRL |=>
        reg_rdata_o[63:12] == 52'h0) else $error("ctrl high bits set");
    a_ctr_width: assert property (reg_rd_i && ctr |=> (reg_rdata_o >> W) == 64'h0)
        else $error("counter read wrong");
    a_ovf_sticky: assert property (!$past(reset_i) |->
        (overflow_status_o & $past(overflow_status_o)) == $past(overflow_status_o))
        else $error("overflow flag lost");
    a_irq_has_flag: assert property (counter_overflow_interrupt_o |-> overflow_status_o != 3'h0)
        else $error("interrupt without overflow");
    a_wr_rdata_zero: assert property (reg_wr_i |=> reg_rdata_o == 64'h0) else $error("write data");
endmodule
bind ffc_fixed_counters ffc_checker #(.W(W)) i_chk (.clk_i(clk_i), .reset_i(reset_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o), .reg_err_o(reg_err_o),
    .counter_overflow_interrupt_o(counter_overflow_interrupt_o),
    .overflow_status_o(overflow_status_o));
`default_nettype wire

// [ffc_core_model.sv]
`timescale 1ns/10ps
`default_nettype none
module ffc_core_model (
    input  wire logic       clk_i,
    input  wire logic       run_i,
    output var  logic [1:0] priv_o,
    output var  logic       mgmt_o,
    output var  logic [2:0] ev_o,
    output var  logic [2:0] sib_o
);
    logic go;
    initial {priv_o, mgmt_o, ev_o, sib_o} = 9'h000;
    // Random privilege, management mode and event levels while running.
    always @(posedge clk_i) begin
        go = run_i;
        #1;
        {priv_o, mgmt_o, ev_o, sib_o} = go ? 9'($urandom) : 9'h000;
    end
endmodule
`default_nettype wire

// [ffc_fixed_counters_tb.sv]
`timescale 1ns/10ps
`default_nettype none
`include "ffc_defines.vh"
module ffc_fixed_counters_tb;
    logic clk_i = 0, reset_i = 1, wr = 0, rdn = 0, run = 0, ack, err, irq, mgmt, qe;
    logic mgmt_d = 0, irq_x = 0, irq_hit = 0;
    logic [11:0] addr = 0;
    logic [63:0] wd = 0, rd, q, ctl = 0, glob = 0;
    logic [1:0]  priv;
    logic [2:0]  ev, sib, ovf, ovf_x = 0;
    logic [47:0] exp_c [3];
    int err_total = 0, compares = 0;
    ffc_core_model i_core (.clk_i(clk_i), .run_i(run), .priv_o(priv), .mgmt_o(mgmt), .ev_o(ev),
        .sib_o(sib));
    ffc_fixed_counters i_dut (.clk_i(clk_i), .reset_i(reset_i), .reg_wr_i(wr), .reg_rd_i(rdn),
        .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rd), .reg_ack_o(ack),
        .reg_err_o(err), .current_privilege_level_i(priv), .system_management_mode_i(mgmt),
        .instr_retired_i(ev[0]), .core_unhalted_i(ev[1]), .ref_unhalted_i(ev[2]),
        .sib_instr_retired_i(sib[0]), .sib_core_unhalted_i(sib[1]),
        .sib_ref_unhalted_i(sib[2]), .counter_overflow_interrupt_o(irq),
        .overflow_status_o(ovf));
    initial forever #5 clk_i = ~clk_i;
    // Reference counts: freeze follows management mode one cycle late.
    always @(posedge clk_i) begin
        mgmt_d  <= mgmt;
        irq_hit <= irq_hit | irq;
        for (int i = 0; i < 3; i++)
            if ((ev[i] || sib[i] && ctl[4*i+2]) && glob[i] && !mgmt_d
                    && ctl[4*i+(priv != 0)]) begin
                exp_c[i] <= exp_c[i] + 1;
                if (&exp_c[i]) begin
                    ovf_x[i] <= 1'b1;
                    if (ctl[4*i+3])
                        irq_x <= 1'b1;
                end
            end
    end
    task chk(input logic [63:0] seen, input logic [63:0] want);
        compares++;
        if (seen !== want) begin
            err_total++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task acc(input logic w, input logic [11:0] a, input logic [63:0] d);
        wr = w;
        rdn = !w;
        addr = a;
        wd = d;
        @(posedge clk_i);
        #1;
        wr = 0;
        rdn = 0;
        q = rd;
        qe = err;
        chk(ack, 1);
        if (w && a >= 12'h309 && a <= 12'h30b) exp_c[a-12'h309] = d[47:0];
        if (w && a == `FFC_ADDR_CTRL) ctl = d & 64'h0fff;
        if (w && a == `FFC_ADDR_GLOB) glob = d & 64'h0007;
        @(posedge clk_i);
        #1;
    endtask
    task complete_run();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #300000;
        err_total++;
        complete_run();
    end
    initial begin
        void'($urandom(61));
        foreach (exp_c[i]) exp_c[i] = 0;
        repeat (3) @(posedge clk_i);
        #1 reset_i = 0;
        acc(0, `FFC_ADDR_CAPS, 0);
        chk(q, 64'h3000);
        acc(1, `FFC_ADDR_CAPS, '1);
        acc(0, `FFC_ADDR_CAPS, 0);
        chk(q, 64'h3000);
        acc(0, 12'h123, 0);
        chk(qe, 1);
        acc(1, `FFC_ADDR_CTRL, '1);
        acc(0, `FFC_ADDR_CTRL, 0);
        chk(q, 64'h0fff);
        $display("register test done");
        for (int t = 0; t < 24; t++) begin
            irq_x = 0;
            irq_hit = 0;
            acc(1, `FFC_ADDR_GLOB, $urandom);
            acc(1, `FFC_ADDR_CTRL, $urandom);
            for (int i = 0; i < 3; i++)
                acc(1, 12'h309 + 12'(i), 48'hffff_ffff_ffc0 | 6'($urandom));
            run = 1;
            repeat (40) @(posedge clk_i);
            #1 run = 0;
            repeat (4) @(posedge clk_i);
            #1;
            for (int i = 0; i < 3; i++) begin
                acc(0, 12'h309 + 12'(i), 0);
                chk(q, {16'h0000, exp_c[i]});
            end
            chk(ovf, ovf_x);
            chk(irq_hit, irq_x);
            $display("count test %0d done", t);
        end
        complete_run();
    end
endmodule
`default_nettype wire
